/* File: core/bytewide_bus_memory_decoder.sv */
// Memory map decoder and bus sequencer for a byte-wide memory module.
// Assumes synchronous inputs, one 20 MHz clock and an AHB-Lite master.
`timescale 1ns/10ps

module bytewide_bus_memory_decoder
(
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // AHB-Lite register slave.
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  // Processor access port.
  input  wire logic                   req_valid_i,
  input  wire bwdec_pkg::mem_req_type req_i,
  output logic                        req_ready_o,
  output bwdec_pkg::mem_rsp_type      rsp_o,
  // Byte-wide bus.
  output logic      [13:0]            bw_addr_o,
  output logic      [1:0]             nvram_bank_o,
  output logic      [7:0]             bw_data_o,
  output logic                        bw_data_oe_o,
  input  wire logic [7:0]             bw_data_i,
  output logic                        bw_write_n_o,
  output logic                        nvram_loader_trigger_n_ce_n_o,
  output logic                        nvram_data_ce_n_o,
  output logic                        periph_sel_lo_n_o,
  output logic                        periph_sel_hi_n_o,
  output logic                        bw_addr_msb_monitor_o,
  // Expanded multiplexed bus.
  output logic      [7:0]             exp_port0_o,
  output logic                        exp_port0_oe_o,
  input  wire logic [7:0]             exp_port0_i,
  output logic      [7:0]             exp_port2_o,
  output logic                        addr_latch_o,
  output logic                        program_store_strobe_n_o,
  output logic                        exp_rd_n_o,
  output logic                        exp_wr_n_o,
  // Reset, loader and supply pins.
  input  wire logic                   loader_trigger_n_i,
  output logic                        boot_mode_o,
  input  wire logic                   supply_low_i,
  input  wire logic                   backup_switch_i,
  input  wire logic                   supply_reset_io_n_i,
  output logic                        supply_reset_io_n_o,
  output logic                        supply_reset_io_n_oe_o,
  output logic                        backup_active_n_o,
  output logic                        core_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  bwdec_pkg::ctrl_type      ctrl;
  bwdec_pkg::ctrl_type      next_ctrl;
  bwdec_pkg::acc_state_type state;
  bwdec_pkg::acc_state_type next_state;
  bwdec_pkg::mem_req_type   cur;
  bwdec_pkg::target_type    tgt;
  bwdec_pkg::target_type    next_tgt;
  logic                     in_reset;
  logic                     next_reset;
  logic                     trig_prev;
  logic                     boot_clear;
  logic                     wr_pend;
  logic [3:0]               wr_ofs;
  logic [31:0]              status_word;
  logic                     addr_phase;

  ////////////////////////////////////////////////////////////////////////////
  // Map decode. The partitionable map is refused in the 128K configuration.
  function automatic bwdec_pkg::target_type decode(bwdec_pkg::ctrl_type c,
                                                   logic loader_trigger_n, logic [15:0] a);
    bwdec_pkg::target_type t;
    logic                  nonpart;
    t       = '0;
    nonpart = c.pm | c.mem_128k;
    if (loader_trigger_n)
    begin
      t.bw        = nonpart ? (c.loader_trigger_n_64k | ~a[15]) : 1'b1;
      t.loader_trigger_n_chip = 1'b1;
    end
    else if (c.periph_space_sel && a[15])
    begin
      t.bw    = 1'b1;
      t.pe_lo = (a[15:14] == bwdec_pkg::PERIPH_LO_BLOCK);
      t.pe_hi = (a[15:14] == bwdec_pkg::PERIPH_HI_BLOCK);
      t.wr_ok = 1'b1;
    end
    else if (nonpart)
    begin
      t.bw    = c.data_64k | ~a[15];
      t.wr_ok = 1'b1;
    end
    else
    begin
      // One common RAM: blocks below the partition hold program and stay read-only.
      t.bw        = 1'b1;
      t.loader_trigger_n_chip = 1'b1;
      t.wr_ok     = (a[15:12] >= c.part_block);
    end
    return t;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////
  // Reset state: the reset input, low supply or a low supply-reset pin.
  // The pull-up on the reset pin lives in the pad; undriven reads high.
  assign next_reset = supply_low_i | ~supply_reset_io_n_i;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      in_reset <= 1'b1;
    else
      in_reset <= next_reset;
  end

  // Supply pins; the supply-reset pin is open drain and only ever pulled low.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core_reset_o           <= 1'b1;
      supply_reset_io_n_o    <= 1'b0;
      supply_reset_io_n_oe_o <= 1'b0;
      backup_active_n_o      <= 1'b1;
    end
    else
    begin
      core_reset_o           <= next_reset;
      supply_reset_io_n_oe_o <= supply_low_i;
      backup_active_n_o      <= ~backup_switch_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap entry. The edge memory resets high, so a trigger already low at
  // release looks like a falling edge and enters loading at power-up.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_prev   <= 1'b1;
      boot_mode_o <= 1'b0;
    end
    else
    begin
      trig_prev <= loader_trigger_n_i;
      if (trig_prev && !loader_trigger_n_i)
        boot_mode_o <= 1'b1;
      else if (boot_clear)
        boot_mode_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY. A write lands at the end of
  // its data phase, so a control read right behind it is served from the merged value.
  assign addr_phase = hsel_i && hready_i && htrans_i[1];
  assign boot_clear = wr_pend && (wr_ofs == bwdec_pkg::STATUS_OFS) &&
                      hwdata_i[bwdec_pkg::ST_BOOT_BIT];

  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_pend && (wr_ofs == bwdec_pkg::CTRL_OFS))
      next_ctrl = bwdec_pkg::ctrl_type'(hwdata_i[bwdec_pkg::CTRL_W-1:0]);
  end

  always_comb
  begin
    status_word                           = '0;
    status_word[bwdec_pkg::ST_BOOT_BIT]   = boot_mode_o;
    status_word[bwdec_pkg::ST_RESET_BIT]  = in_reset;
    status_word[bwdec_pkg::ST_SUPPLY_BIT] = supply_low_i;
    status_word[bwdec_pkg::ST_BACKUP_BIT] = backup_switch_i;
    status_word[bwdec_pkg::ST_PART_BIT]   = ~(ctrl.pm | ctrl.mem_128k);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_pend     <= 1'b0;
      wr_ofs      <= 4'h0;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_pend  <= addr_phase && hwrite_i;
      wr_ofs   <= haddr_i[3:0];
      hrdata_o <= 32'h0000_0000;
      if (addr_phase && !hwrite_i && (haddr_i[31:4] == 28'h0000000))
      begin
        if (haddr_i[3:0] == bwdec_pkg::CTRL_OFS)
          hrdata_o <= {{(32-bwdec_pkg::CTRL_W){1'b0}}, next_ctrl};
        else if (haddr_i[3:0] == bwdec_pkg::STATUS_OFS)
          hrdata_o <= status_word;
      end
    end
  end

  // Control register; written at any address whose low four bits are offset zero.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl <= bwdec_pkg::ctrl_type'(bwdec_pkg::CTRL_RESET);
    else
      ctrl <= next_ctrl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: setup drives address, strobe samples data, done answers.
  assign next_tgt = decode(ctrl, req_i.loader_trigger_n, req_i.addr);

  always_comb
  begin
    next_state = state;
    case (state)
      bwdec_pkg::ST_IDLE:   if (req_valid_i && !next_reset) next_state = bwdec_pkg::ST_SETUP;
      bwdec_pkg::ST_SETUP:  next_state = bwdec_pkg::ST_STROBE;
      bwdec_pkg::ST_STROBE: next_state = bwdec_pkg::ST_DONE;
      bwdec_pkg::ST_DONE:   next_state = bwdec_pkg::ST_IDLE;
      default:              next_state = bwdec_pkg::ST_IDLE;
    endcase
    if (next_reset)
      next_state = bwdec_pkg::ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state       <= bwdec_pkg::ST_IDLE;
      cur         <= '0;
      tgt         <= '0;
      req_ready_o <= 1'b0;
      rsp_o       <= '0;
    end
    else
    begin
      state       <= next_state;
      req_ready_o <= (next_state == bwdec_pkg::ST_IDLE) && !next_reset;
      rsp_o.done  <= (next_state == bwdec_pkg::ST_DONE);
      if (state == bwdec_pkg::ST_IDLE && next_state == bwdec_pkg::ST_SETUP)
      begin
        cur <= req_i;
        tgt <= next_tgt;
      end
      if (state == bwdec_pkg::ST_STROBE && !cur.write)
        rsp_o.rdata <= tgt.bw ? bw_data_i : exp_port0_i;
    end
  end

  // Byte-wide bus pins. The write strobe is gated by the decoded write
  // permission, and the same strobe serves SRAM and peripherals alike.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bw_addr_o             <= 14'h0000;
      nvram_bank_o          <= 2'h0;
      bw_data_o             <= 8'h00;
      bw_data_oe_o          <= 1'b0;
      bw_write_n_o          <= 1'b1;
      nvram_loader_trigger_n_ce_n_o     <= 1'b1;
      nvram_data_ce_n_o     <= 1'b1;
      periph_sel_lo_n_o     <= 1'b1;
      periph_sel_hi_n_o     <= 1'b1;
      bw_addr_msb_monitor_o <= 1'b0;
    end
    else if (next_reset)
    begin
      bw_data_oe_o      <= 1'b0;
      bw_write_n_o      <= 1'b1;
      nvram_loader_trigger_n_ce_n_o <= 1'b1;
      nvram_data_ce_n_o <= 1'b1;
      periph_sel_lo_n_o <= 1'b1;
      periph_sel_hi_n_o <= 1'b1;
    end
    else
    begin
      bw_addr_msb_monitor_o <= (next_state == bwdec_pkg::ST_SETUP) ?
                               req_i.addr[15] : cur.addr[15];
      if (next_state == bwdec_pkg::ST_SETUP && next_tgt.bw)
      begin
        bw_addr_o         <= req_i.addr[13:0];
        nvram_bank_o      <= req_i.addr[15:14];
        bw_data_o         <= req_i.wdata;
        bw_data_oe_o      <= req_i.write && next_tgt.wr_ok;
        nvram_loader_trigger_n_ce_n_o <= ~(next_tgt.loader_trigger_n_chip && !next_tgt.pe_lo && !next_tgt.pe_hi);
        nvram_data_ce_n_o <= ~(!next_tgt.loader_trigger_n_chip && !next_tgt.pe_lo && !next_tgt.pe_hi);
        periph_sel_lo_n_o <= ~next_tgt.pe_lo;
        periph_sel_hi_n_o <= ~next_tgt.pe_hi;
      end
      else if (next_state == bwdec_pkg::ST_IDLE)
      begin
        bw_data_oe_o      <= 1'b0;
        nvram_loader_trigger_n_ce_n_o <= 1'b1;
        nvram_data_ce_n_o <= 1'b1;
        periph_sel_lo_n_o <= 1'b1;
        periph_sel_hi_n_o <= 1'b1;
      end
      bw_write_n_o <= ~(next_state == bwdec_pkg::ST_STROBE && tgt.bw &&
                        cur.write && tgt.wr_ok);
    end
  end

  // Expanded bus pins: latch phase with the address, then the strobe phase.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      exp_port0_o              <= 8'h00;
      exp_port0_oe_o           <= 1'b0;
      exp_port2_o              <= 8'h00;
      addr_latch_o             <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      exp_rd_n_o               <= 1'b1;
      exp_wr_n_o               <= 1'b1;
    end
    else
    begin
      addr_latch_o             <= 1'b0;
      program_store_strobe_n_o <= 1'b1;
      exp_rd_n_o               <= 1'b1;
      exp_wr_n_o               <= 1'b1;
      exp_port0_oe_o           <= 1'b0;
      if (next_state == bwdec_pkg::ST_SETUP && !next_tgt.bw)
      begin
        addr_latch_o   <= 1'b1;
        exp_port0_o    <= req_i.addr[7:0];
        exp_port0_oe_o <= 1'b1;
        exp_port2_o    <= req_i.addr[15:8];
      end
      else if (next_state == bwdec_pkg::ST_STROBE && !tgt.bw)
      begin
        program_store_strobe_n_o <= ~cur.loader_trigger_n;
        exp_rd_n_o               <= cur.loader_trigger_n | cur.write;
        exp_wr_n_o               <= ~(cur.write && !cur.loader_trigger_n);
        exp_port0_o              <= cur.wdata;
        exp_port0_oe_o           <= cur.write && !cur.loader_trigger_n;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_exp_latch;
    addr_latch_o && program_store_strobe_n_o;
  endsequence
  sequence s_exp_fetch;
    !addr_latch_o && !program_store_strobe_n_o;
  endsequence

  property p_reset_pin;
    @(posedge clk_i) disable iff (rst_i) !supply_reset_io_n_i |=> core_reset_o && in_reset;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("external reset not taken");

  property p_supply_drive;
    @(posedge clk_i) disable iff (rst_i)
      supply_low_i |=> supply_reset_io_n_oe_o && !supply_reset_io_n_o;
  endproperty
  a_supply_drive: assert property (p_supply_drive) else $error("supply reset not driven");

  property p_supply_quiet;
    @(posedge clk_i) disable iff (rst_i) supply_low_i |=> bw_write_n_o && periph_sel_lo_n_o
      && periph_sel_hi_n_o && nvram_loader_trigger_n_ce_n_o && nvram_data_ce_n_o;
  endproperty
  a_supply_quiet: assert property (p_supply_quiet) else $error("enable active in reset");

  property p_pe_lo;
    @(posedge clk_i) disable iff (rst_i)
      !periph_sel_lo_n_o |-> ctrl.periph_space_sel && !cur.loader_trigger_n && cur.addr[15:14] == 2'h2;
  endproperty
  a_pe_lo: assert property (p_pe_lo) else $error("lower peripheral enable misdecoded");

  property p_pe_hi;
    @(posedge clk_i) disable iff (rst_i)
      !periph_sel_hi_n_o |-> ctrl.periph_space_sel && !cur.loader_trigger_n && cur.addr[15:14] == 2'h3;
  endproperty
  a_pe_hi: assert property (p_pe_hi) else $error("upper peripheral enable misdecoded");

  property p_write_protect;
    @(posedge clk_i) disable iff (rst_i)
      !bw_write_n_o |-> !cur.loader_trigger_n && cur.write && $past(state) == bwdec_pkg::ST_SETUP &&
        (ctrl.pm || ctrl.mem_128k || (ctrl.periph_space_sel && cur.addr[15]) ||
         cur.addr[15:12] >= ctrl.part_block);
  endproperty
  a_write_protect: assert property (p_write_protect) else $error("write in program");

  property p_boot_edge;
    @(posedge clk_i) disable iff (rst_i)
      $fell(loader_trigger_n_i) |=> boot_mode_o;
  endproperty
  a_boot_edge: assert property (p_boot_edge) else $error("loader edge missed");

  property p_backup;
    @(posedge clk_i) disable iff (rst_i) backup_switch_i |=> !backup_active_n_o;
  endproperty
  a_backup: assert property (p_backup) else $error("backup indication missing");

  property p_exp_fetch;
    @(posedge clk_i) disable iff (rst_i)
      s_exp_latch ##0 (state == bwdec_pkg::ST_SETUP && cur.loader_trigger_n && !next_reset)
      |=> s_exp_fetch ##1 program_store_strobe_n_o;
  endproperty
  a_exp_fetch: assert property (p_exp_fetch) else $error("fetch strobe out of order");

endmodule : bytewide_bus_memory_decoder

/* File: include/bwdec_pkg.sv */
// Constants and carrier types for the byte-wide bus memory decoder.
// Assumes a 32-bit AHB-Lite register port and an 8-bit processor access port.
package bwdec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: byte offsets inside the slave window.
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // Control register: low nine bits laid out as ctrl_type, the rest read zero.
  localparam int          CTRL_W     = 9;
  localparam logic [8:0]  CTRL_RESET = 9'h002;

  // Status register bit positions.
  localparam int ST_BOOT_BIT   = 0;
  localparam int ST_RESET_BIT  = 1;
  localparam int ST_SUPPLY_BIT = 2;
  localparam int ST_BACKUP_BIT = 3;
  localparam int ST_PART_BIT   = 4;

  // Memory map boundaries, as upper address bits.
  localparam logic [1:0] PERIPH_LO_BLOCK = 2'h2;
  localparam logic [1:0] PERIPH_HI_BLOCK = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer states, Gray coded along idle-setup-strobe-done.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b11,
    ST_DONE   = 2'b10
  } acc_state_type;

  // Processor access request and answer.
  typedef struct packed {
    logic        loader_trigger_n;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_type;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } mem_rsp_type;

  // Decoded target of one access.
  typedef struct packed {
    logic bw;
    logic loader_trigger_n_chip;
    logic pe_lo;
    logic pe_hi;
    logic wr_ok;
  } target_type;

  // Memory map configuration, bit 0 upward: pes, pm, loader_trigger_n_64k, data_64k, mem_128k, part.
  typedef struct packed {
    logic [3:0] part_block;
    logic       mem_128k;
    logic       data_64k;
    logic       loader_trigger_n_64k;
    logic       pm;
    logic       periph_space_sel;
  } ctrl_type;

endpackage : bwdec_pkg

/* File: verif/bw_memory_model.sv */
// Behavioural byte-wide SRAM and peripheral chips on the decoder's far side.
// Assumes registered strobes and one select that is low for any enabled chip.
`timescale 1ns/10ps

module bw_memory_model
(
  // Clock.
  input  wire logic        clk_i,
  // Byte-wide bus.
  input  wire logic [13:0] addr_i,
  input  wire logic [1:0]  bank_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        write_n_i,
  input  wire logic        sel_n_i,
  output logic      [7:0]  data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Store on the shared write strobe, the peripherals use the same one.
  always @(posedge clk_i)
  begin
    if (!write_n_i && !sel_n_i)
      mem[{bank_i, addr_i}] <= data_i;
    if (!sel_n_i)
      last <= mem[{bank_i, addr_i}];
  end

  // A deselected bus shows the inverse of the last byte, so stale data never matches.
  assign data_o = sel_n_i ? ~last : mem[{bank_i, addr_i}];
endmodule : bw_memory_model

/* File: verif/bytewide_bus_memory_decoder_tb.sv */
// Self-checking bench for the byte-wide bus memory decoder.
// Assumes the memory model is compiled first and the expanded bus reads 3Ch.
`timescale 1ns/10ps

module bytewide_bus_memory_decoder_tb;
  // Bench state; every input has a value at time zero.
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   hsel = 1'b0;
  logic                   hwrite = 1'b0;
  logic [1:0]             htrans = 2'h0;
  logic [31:0]            haddr = 32'h0;
  logic [31:0]            hwdata = 32'h0;
  logic                   req_valid = 1'b0;
  bwdec_pkg::mem_req_type req = '0;
  logic                   loader_n = 1'b1;
  logic                   sup_low = 1'b0;
  logic                   bkup = 1'b0;
  logic                   ext_low = 1'b0;
  logic [31:0]            hrdata, q;
  logic                   hready, req_ready, bw_we_n, pce_n, dce_n, pe_lo_n, pe_hi_n;
  logic                   msb, ale, program_store_strobe_n_n, rd_n, boot, sr_oe, bk_n, core_rst, sr_pin;
  bwdec_pkg::mem_rsp_type rsp;
  logic [13:0]            bw_addr;
  logic [1:0]             bank;
  logic [7:0]             bw_wdata, bw_rdata, b;
  logic [7:0]             seen = 8'h00;
  logic [7:0]             p0, p2;
  logic [7:0]             lat = 8'h00;
  logic                   xwr_n;
  logic                   xw = 1'b0;
  logic                   mon = 1'b0;
  int                     fails = 0;
  int                     n_tests = 0;
  int                     cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  always #25 clk_i = ~clk_i;
  // The supply-reset pin has a pull-up; either party may pull it low.
  assign sr_pin = ~(sr_oe | ext_low);

  bytewide_bus_memory_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
    .rsp_o(rsp), .bw_addr_o(bw_addr), .nvram_bank_o(bank), .bw_data_o(bw_wdata),
    .bw_data_oe_o(), .bw_data_i(bw_rdata), .bw_write_n_o(bw_we_n),
    .nvram_loader_trigger_n_ce_n_o(pce_n), .nvram_data_ce_n_o(dce_n), .periph_sel_lo_n_o(pe_lo_n),
    .periph_sel_hi_n_o(pe_hi_n), .bw_addr_msb_monitor_o(msb), .exp_port0_o(p0),
    .exp_port0_oe_o(), .exp_port0_i(8'h3C), .exp_port2_o(p2), .addr_latch_o(ale),
    .program_store_strobe_n_o(program_store_strobe_n_n), .exp_rd_n_o(rd_n), .exp_wr_n_o(xwr_n),
    .loader_trigger_n_i(loader_n), .boot_mode_o(boot), .supply_low_i(sup_low),
    .backup_switch_i(bkup), .supply_reset_io_n_i(sr_pin), .supply_reset_io_n_o(),
    .supply_reset_io_n_oe_o(sr_oe), .backup_active_n_o(bk_n), .core_reset_o(core_rst));

  bw_memory_model model (.clk_i(clk_i), .addr_i(bw_addr), .bank_i(bank),
    .data_i(bw_wdata), .write_n_i(bw_we_n), .sel_n_i(&{pce_n, dce_n, pe_lo_n, pe_hi_n}),
    .data_o(bw_rdata));

  // Far-side address latch; it closes as the strobe falls, taken at that edge.
  always @(posedge clk_i)
  begin
    if (ale)
      lat <= p0;
  end

  // Strobes seen during an access: dce, ale, program_store_strobe_n, rd, pce, pe_hi, pe_lo, write.
  always @(posedge clk_i)
  begin
    if (mon)
    begin
      seen <= seen | {~dce_n, ale, ~program_store_strobe_n_n, ~rd_n, ~pce_n, ~pe_hi_n, ~pe_lo_n, ~bw_we_n};
      xw   <= xw | ~xwr_n;
    end
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single word transfer; read data is taken at the data phase edge.
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb

  // One processor access; returns after the strobes it caused have landed in seen.
  task acc(input logic p, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    seen <= 8'h00;
    xw <= 1'b0;
    mon <= 1'b1;
    req <= '{loader_trigger_n: p, write: w, addr: a, wdata: d};
    req_valid <= 1'b1;
    do @(posedge clk_i); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge clk_i); while (rsp.done !== 1'b1);
    b = rsp.rdata;
    mon <= 1'b0;
    @(negedge clk_i);
  endtask : acc

  ////////////////////////////////////////////////////////////////////////////
  task t_bytewide;
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl_reset", 32'h002, q);
    acc(1'b0, 1'b1, 16'h1234, 8'hA5);
    chk("data_write", 8'h81, seen);
    acc(1'b0, 1'b0, 16'h1234, 8'h00);
    chk("read_back", 8'hA5, b);
    chk("bw_addr", 14'h1234, bw_addr);
    chk("monitor_lo", 1'b0, msb);
    acc(1'b1, 1'b1, 16'h0100, 8'h5A);
    chk("loader_trigger_n_protect", 8'h08, seen);
  endtask : t_bytewide

  task t_expanded;
    acc(1'b0, 1'b0, 16'h9055, 8'h00);
    chk("exp_read", 8'h50, seen);
    chk("exp_latch", 16'h9055, {p2, lat});
    chk("exp_data", 8'h3C, b);
    chk("monitor_hi", 1'b1, msb);
    acc(1'b0, 1'b1, 16'h9055, 8'h77);
    chk("exp_write", 9'h140, {xw, seen});
    acc(1'b1, 1'b0, 16'h8000, 8'h00);
    chk("exp_fetch", 8'h60, seen);
  endtask : t_expanded

  task t_periph;
    ahb(1'b1, 32'h0, 32'h003);
    acc(1'b0, 1'b1, 16'h8100, 8'h11);
    chk("pe_lo_write", 8'h03, seen);
    acc(1'b0, 1'b0, 16'hC000, 8'h00);
    chk("pe_hi_read", 8'h04, seen);
    acc(1'b0, 1'b0, 16'hBFFF, 8'h00);
    chk("pe_lo_edge", 8'h02, seen);
    acc(1'b1, 1'b0, 16'h8000, 8'h00);
    chk("pe_loader_trigger_n_none", 8'h60, seen);
  endtask : t_periph

  task t_range;
    ahb(1'b1, 32'h0, 32'h006);
    acc(1'b1, 1'b0, 16'h9000, 8'h00);
    chk("loader_trigger_n_64k", 8'h08, seen);
    ahb(1'b1, 32'h0, 32'h00A);
    acc(1'b0, 1'b0, 16'h9000, 8'h00);
    chk("data_64k", 8'h80, seen);
  endtask : t_range

  task t_partition;
    ahb(1'b1, 32'h0, 32'h080);
    ahb(1'b0, 32'h4, 32'h0);
    chk("part_on", 32'h10, q & 32'h10);
    acc(1'b0, 1'b1, 16'h2000, 8'h22);
    chk("part_loader_trigger_n_blk", 8'h08, seen);
    acc(1'b0, 1'b1, 16'h5000, 8'h33);
    chk("part_data_blk", 8'h09, seen);
    ahb(1'b1, 32'h0, 32'h090);
    ahb(1'b0, 32'h4, 32'h0);
    chk("part_128k", 32'h0, q & 32'h10);
    acc(1'b0, 1'b1, 16'h2000, 8'h44);
    chk("nopart_write", 8'h81, seen);
  endtask : t_partition

  task t_loader;
    // One clean falling edge, as a debounced source gives.
    @(posedge clk_i);
    loader_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    loader_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("boot_mode", 1'b1, boot);
    ahb(1'b1, 32'h4, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    chk("boot_clear", 32'h0, q & 32'h1);
    // A trigger held low through a reset enters loading at release.
    loader_n <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("boot_powerup", 1'b1, boot);
    loader_n <= 1'b1;
  endtask : t_loader

  task t_supply;
    sup_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("pin_drive", 1'b1, sr_oe);
    chk("enables_off", 5'h1F, {pce_n, dce_n, pe_lo_n, pe_hi_n, bw_we_n});
    chk("supply_rst", 2'h2, {core_rst, req_ready});
    sup_low <= 1'b0;
    repeat (3) @(posedge clk_i);
    ext_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("pin_reset", 1'b1, core_rst);
    ext_low <= 1'b0;
    bkup <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("backup", 1'b0, bk_n);
  endtask : t_supply

  task complete_run;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then one scenario after another.
  initial
  begin
    repeat (12) @(posedge clk_i);
    chk("in_reset", 1'b1, core_rst);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("out_reset", 1'b0, core_rst);
    t_bytewide();
    t_expanded();
    t_periph();
    t_range();
    t_partition();
    t_loader();
    t_supply();
    complete_run();
  end
endmodule : bytewide_bus_memory_decoder_tb
